/* shared/flash_host_pkg.sv */
package flash_host_pkg;

   localparam int CLK_NS = 10;

   // pin timing of one bus cycle, in ns, then in clock cycles
   localparam int T_SETUP_NS = 10;
   localparam int T_PULSE_NS = 40;
   localparam int T_HOLD_NS = 10;
   localparam int T_ACC_NS = 70;
   localparam int T_GAP_NS = 20;

   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int SETUP_CYC = ns_to_cyc(T_SETUP_NS);
   localparam int PULSE_CYC = ns_to_cyc(T_PULSE_NS);
   localparam int HOLD_CYC = ns_to_cyc(T_HOLD_NS);
   localparam int ACC_CYC = ns_to_cyc(T_ACC_NS);
   localparam int GAP_CYC = ns_to_cyc(T_GAP_NS);
   localparam int SYNC_CYC = 2;

   // command addresses and codes
   localparam logic [15:0] ADDR_UNLOCK1 = 16'h5555;
   localparam logic [15:0] ADDR_UNLOCK2 = 16'h2aaa;
   localparam logic [15:0] ADDR_LOCK_QUERY = 16'h0002;
   localparam logic [15:0] BOOT_TOP = 16'h1fff;
   localparam logic [7:0] CODE_UNLOCK1 = 8'haa;
   localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
   localparam logic [7:0] CODE_SETUP = 8'h80;
   localparam logic [7:0] CODE_PROGRAM = 8'ha0;
   localparam logic [7:0] CODE_ID_ENTRY = 8'h90;
   localparam logic [7:0] CODE_ID_EXIT = 8'hf0;
   localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
   localparam logic [7:0] CODE_MAIN_ERASE = 8'h30;
   localparam logic [7:0] CODE_LOCKOUT = 8'h40;

   // register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_RDATA = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_VERR = 2;
   localparam int ST_LOCK = 3;
   localparam int ST_IDMODE = 4;
   localparam logic [15:0] RST_WORD = 16'h0000;

   typedef enum logic [2:0] {
      OP_READ, OP_PROGRAM, OP_CHIP_ERASE, OP_MAIN_ERASE,
      OP_LOCKOUT, OP_ID_ENTRY, OP_ID_EXIT, OP_ID_EXIT_SHORT
   } op_e;

   typedef struct packed {
      logic wr;
      logic [15:0] addr;
      logic [15:0] data;
   } bus_req_s;

endpackage

/* src/bus_cycle.sv */
`timescale 1ns/1ns
module bus_cycle (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic start,
   input flash_host_pkg::bus_req_s req,
   input wire logic [15:0] dq_sync,
   output logic done,
   output logic [15:0] rdata,
   output logic [15:0] addr_q,
   output logic ce_n_q,
   output logic oe_n_q,
   output logic we_n_q,
   output logic [15:0] dq_q,
   output logic dq_oe_q
);
   typedef enum logic [2:0] {B_IDLE, B_SETUP, B_STROBE, B_HOLD, B_GAP} bst_e;
   bst_e st_q, st_d;
   logic [7:0] cnt_q, cnt_d;
   logic wr_q, wr_d;
   logic [15:0] addr_d, dq_d, rdata_d;
   logic ce_n_d, oe_n_d, we_n_d, dq_oe_d, done_d;

   always_comb begin
      st_d = st_q;
      cnt_d = (cnt_q == 8'h00) ? 8'h00 : cnt_q - 8'h01;
      wr_d = wr_q;
      addr_d = addr_q;
      dq_d = dq_q;
      rdata_d = rdata;
      ce_n_d = ce_n_q;
      oe_n_d = oe_n_q;
      we_n_d = we_n_q;
      dq_oe_d = dq_oe_q;
      done_d = 1'b0;
      case (st_q)
         B_IDLE: begin
            if (start) begin
               // address settles before any strobe falls
               wr_d = req.wr;
               addr_d = req.addr;
               dq_d = req.data;
               dq_oe_d = req.wr;
               ce_n_d = 1'b0;
               cnt_d = 8'(flash_host_pkg::SETUP_CYC - 1);
               st_d = B_SETUP;
            end
         end
         B_SETUP: begin
            if (cnt_q == 8'h00) begin
               // writes never run with the output gate low
               we_n_d = !wr_q;
               oe_n_d = wr_q;
               cnt_d = wr_q ? 8'(flash_host_pkg::PULSE_CYC - 1)
                  : 8'(flash_host_pkg::ACC_CYC
                       + flash_host_pkg::SYNC_CYC - 1);
               st_d = B_STROBE;
            end
         end
         B_STROBE: begin
            if (cnt_q == 8'h00) begin
               // strobe rises first so data is caught before ce_n
               we_n_d = 1'b1;
               oe_n_d = 1'b1;
               if (!wr_q) begin
                  rdata_d = dq_sync;
               end
               cnt_d = 8'(flash_host_pkg::HOLD_CYC - 1);
               st_d = B_HOLD;
            end
         end
         B_HOLD: begin
            if (cnt_q == 8'h00) begin
               ce_n_d = 1'b1;
               dq_oe_d = 1'b0;
               cnt_d = 8'(flash_host_pkg::GAP_CYC - 1);
               st_d = B_GAP;
            end
         end
         B_GAP: begin
            if (cnt_q == 8'h00) begin
               done_d = 1'b1;
               st_d = B_IDLE;
            end
         end
         default: st_d = B_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= B_IDLE;
         cnt_q <= 8'h00;
         wr_q <= 1'b0;
         addr_q <= 16'h0000;
         dq_q <= 16'h0000;
         rdata <= 16'h0000;
         ce_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         we_n_q <= 1'b1;
         dq_oe_q <= 1'b0;
         done <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         wr_q <= wr_d;
         addr_q <= addr_d;
         dq_q <= dq_d;
         rdata <= rdata_d;
         ce_n_q <= ce_n_d;
         oe_n_q <= oe_n_d;
         we_n_q <= we_n_d;
         dq_oe_q <= dq_oe_d;
         done <= done_d;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_we_pulse_width: assert property ($fell(we_n_q) |-> !we_n_q[*4])
      else $error("write strobe pulse too short");
   a_write_no_oe: assert property (!we_n_q |-> oe_n_q && !ce_n_q)
      else $error("write strobe low with output gate low");
   a_write_hold: assert property (!we_n_q |=> $stable(dq_q)
      && $stable(addr_q) && dq_oe_q)
      else $error("address or data moved around write strobe");
   a_no_contention: assert property (dq_oe_q |-> oe_n_q)
      else $error("driving data while output gate low");
endmodule

/* src/flash_host.sv */
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
// Notes on behaviour
// - main erase: six writes, last 30
// - word program is four writes
// - lockout needs fixed six-write sequence
// - exit identify mode after lock check
// - commands start with two unlock writes, except the single F0 identify exit
// - identify exit by single F0 allowed
module flash_host (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [15:0] flash_addr,
   output logic ce_n,
   output logic oe_n,
   output logic we_n,
   output logic [15:0] dq_o,
   output logic dq_oe,
   input wire logic [15:0] dq_i
);
   typedef enum logic [2:0] {S_IDLE, S_SEQ, S_SEQ_W, S_POLL, S_POLL_W} st_e;

   // step k of the write sequence for each command
   function automatic flash_host_pkg::bus_req_s seq_step(
      input flash_host_pkg::op_e op, input logic [2:0] k,
      input logic [15:0] ua, input logic [15:0] ud);
      flash_host_pkg::bus_req_s r;
      r.wr = 1'b1;
      r.addr = flash_host_pkg::ADDR_UNLOCK1;
      r.data = {8'h00, flash_host_pkg::CODE_UNLOCK1};
      case (k)
         3'd1: begin
            r.addr = flash_host_pkg::ADDR_UNLOCK2;
            r.data = {8'h00, flash_host_pkg::CODE_UNLOCK2};
         end
         3'd2: r.data = {8'h00, flash_host_pkg::CODE_SETUP};
         3'd4: begin
            r.addr = flash_host_pkg::ADDR_UNLOCK2;
            r.data = {8'h00, flash_host_pkg::CODE_UNLOCK2};
         end
         default: ;
      endcase
      case (op)
         flash_host_pkg::OP_READ: begin
            r.wr = 1'b0;
            r.addr = ua;
         end
         flash_host_pkg::OP_ID_EXIT_SHORT: begin
            r.addr = ua;
            r.data = {8'h00, flash_host_pkg::CODE_ID_EXIT};
         end
         flash_host_pkg::OP_PROGRAM: begin
            if (k == 3'd2) r.data = {8'h00, flash_host_pkg::CODE_PROGRAM};
            if (k == 3'd3) begin
               r.addr = ua;
               r.data = ud;
            end
         end
         flash_host_pkg::OP_ID_ENTRY: begin
            if (k == 3'd2) r.data = {8'h00, flash_host_pkg::CODE_ID_ENTRY};
         end
         flash_host_pkg::OP_ID_EXIT: begin
            if (k == 3'd2) r.data = {8'h00, flash_host_pkg::CODE_ID_EXIT};
         end
         flash_host_pkg::OP_CHIP_ERASE: begin
            if (k == 3'd5) r.data = {8'h00, flash_host_pkg::CODE_CHIP_ERASE};
         end
         flash_host_pkg::OP_MAIN_ERASE: begin
            if (k == 3'd5) r.data = {8'h00, flash_host_pkg::CODE_MAIN_ERASE};
         end
         flash_host_pkg::OP_LOCKOUT: begin
            if (k == 3'd5) r.data = {8'h00, flash_host_pkg::CODE_LOCKOUT};
         end
         default: ;
      endcase
      return r;
   endfunction

   function automatic logic [2:0] seq_len(input flash_host_pkg::op_e op);
      case (op)
         flash_host_pkg::OP_READ: return 3'd1;
         flash_host_pkg::OP_ID_EXIT_SHORT: return 3'd1;
         flash_host_pkg::OP_PROGRAM: return 3'd4;
         flash_host_pkg::OP_ID_ENTRY: return 3'd3;
         flash_host_pkg::OP_ID_EXIT: return 3'd3;
         default: return 3'd6;
      endcase
   endfunction

   function automatic logic needs_poll(input flash_host_pkg::op_e op);
      return op == flash_host_pkg::OP_PROGRAM
         || op == flash_host_pkg::OP_CHIP_ERASE
         || op == flash_host_pkg::OP_MAIN_ERASE
         || op == flash_host_pkg::OP_LOCKOUT;
   endfunction

   logic [15:0] dq_sync, bus_rdata;
   logic bus_done;
   st_e st_q, st_d;
   flash_host_pkg::op_e op_q, op_d;
   logic [2:0] idx_q, idx_d;
   logic start_q, start_d;
   flash_host_pkg::bus_req_s req_q, req_d;
   logic first_q, first_d, tog_q, tog_d;
   logic [15:0] uaddr_q, uaddr_d, wdata_q, wdata_d, rdata_q, rdata_d;
   logic done_q, done_d, verr_q, verr_d, lock_q, lock_d, idm_q, idm_d;
   logic [31:0] prdata_d;
   logic pready_d, pslverr_d, acc, wr_acc, finish;

   sync2 #(.WIDTH(16)) u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .d(dq_i),
      .q(dq_sync)
   );

   bus_cycle u_bus (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .start(start_q),
      .req(req_q),
      .dq_sync(dq_sync),
      .done(bus_done),
      .rdata(bus_rdata),
      .addr_q(flash_addr),
      .ce_n_q(ce_n),
      .oe_n_q(oe_n),
      .we_n_q(we_n),
      .dq_q(dq_o),
      .dq_oe_q(dq_oe)
   );

   assign acc = psel && penable && pready;
   assign wr_acc = acc && pwrite;

   // apb slave: one wait-free access phase, error on unmapped offsets
   always_comb begin
      pready_d = psel && !penable;
      pslverr_d = 1'b0;
      prdata_d = 32'h0000_0000;
      if (psel && !penable) begin
         case (paddr)
            flash_host_pkg::REG_CTRL: prdata_d = {29'h0, op_q};
            flash_host_pkg::REG_ADDR: prdata_d = {16'h0, uaddr_q};
            flash_host_pkg::REG_WDATA: prdata_d = {16'h0, wdata_q};
            flash_host_pkg::REG_RDATA: prdata_d = {16'h0, rdata_q};
            flash_host_pkg::REG_STATUS: prdata_d = {27'h0, idm_q, lock_q,
               verr_q, done_q, st_q != S_IDLE};
            default: pslverr_d = 1'b1;
         endcase
      end
   end

   always_comb begin
      st_d = st_q;
      op_d = op_q;
      idx_d = idx_q;
      start_d = 1'b0;
      req_d = req_q;
      first_d = first_q;
      tog_d = tog_q;
      uaddr_d = uaddr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      verr_d = verr_q;
      lock_d = lock_q;
      idm_d = idm_q;
      finish = 1'b0;
      if (wr_acc && paddr == flash_host_pkg::REG_ADDR && st_q == S_IDLE)
         uaddr_d = pwdata[15:0];
      if (wr_acc && paddr == flash_host_pkg::REG_WDATA && st_q == S_IDLE)
         wdata_d = pwdata[15:0];
      case (st_q)
         S_IDLE: begin
            if (wr_acc && paddr == flash_host_pkg::REG_CTRL) begin
               op_d = flash_host_pkg::op_e'(pwdata[2:0]);
               idx_d = 3'd0;
               verr_d = 1'b0;
               st_d = S_SEQ;
            end
         end
         S_SEQ: begin
            // every step goes out unbroken, so the device never sees
            // a sequence it would have to drop
            req_d = seq_step(op_q, idx_q, uaddr_q, wdata_q);
            start_d = 1'b1;
            st_d = S_SEQ_W;
         end
         S_SEQ_W: begin
            if (bus_done) begin
               if (!req_q.wr) begin
                  rdata_d = bus_rdata;
                  if (idm_q && uaddr_q == flash_host_pkg::ADDR_LOCK_QUERY)
                     lock_d = bus_rdata[0];
               end
               if (idx_q + 3'd1 == seq_len(op_q)) begin
                  if (needs_poll(op_q)) begin
                     first_d = 1'b1;
                     st_d = S_POLL;
                  end else begin
                     finish = 1'b1;
                     st_d = S_IDLE;
                  end
                  if (op_q == flash_host_pkg::OP_ID_ENTRY) idm_d = 1'b1;
                  if (op_q == flash_host_pkg::OP_ID_EXIT
                      || op_q == flash_host_pkg::OP_ID_EXIT_SHORT)
                     idm_d = 1'b0;
               end else begin
                  idx_d = idx_q + 3'd1;
                  st_d = S_SEQ;
               end
            end
         end
         S_POLL: begin
            req_d = '{wr: 1'b0, addr: uaddr_q, data: 16'h0000};
            start_d = 1'b1;
            st_d = S_POLL_W;
         end
         S_POLL_W: begin
            if (bus_done) begin
               first_d = 1'b0;
               tog_d = bus_rdata[6];
               // two equal toggle bits in a row: operation over and this
               // read already holds true data
               if (!first_q && bus_rdata[6] == tog_q) begin
                  rdata_d = bus_rdata;
                  if (op_q == flash_host_pkg::OP_PROGRAM)
                     verr_d = bus_rdata != wdata_q;
                  finish = 1'b1;
                  st_d = S_IDLE;
               end else begin
                  st_d = S_POLL;
               end
            end
         end
         default: st_d = S_IDLE;
      endcase
      // hardware set beats the software clear in the same cycle
      done_d = finish || (done_q && !(wr_acc
         && paddr == flash_host_pkg::REG_STATUS
         && pwdata[flash_host_pkg::ST_DONE]));
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         st_q <= S_IDLE;
         op_q <= flash_host_pkg::OP_READ;
         idx_q <= 3'd0;
         start_q <= 1'b0;
         req_q <= '0;
         first_q <= 1'b0;
         tog_q <= 1'b0;
         uaddr_q <= flash_host_pkg::RST_WORD;
         wdata_q <= flash_host_pkg::RST_WORD;
         rdata_q <= flash_host_pkg::RST_WORD;
         done_q <= 1'b0;
         verr_q <= 1'b0;
         lock_q <= 1'b0;
         idm_q <= 1'b0;
      end else begin
         prdata <= prdata_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
         st_q <= st_d;
         op_q <= op_d;
         idx_q <= idx_d;
         start_q <= start_d;
         req_q <= req_d;
         first_q <= first_d;
         tog_q <= tog_d;
         uaddr_q <= uaddr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         done_q <= done_d;
         verr_q <= verr_d;
         lock_q <= lock_d;
         idm_q <= idm_d;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_unlock_first: assert property (start_q && idx_q == 3'd0
      && op_q != flash_host_pkg::OP_READ
      && op_q != flash_host_pkg::OP_ID_EXIT_SHORT
      |-> req_q.addr == 16'h5555 && req_q.data[7:0] == 8'haa)
      else $error("command did not open with first unlock write");
   a_unlock_second: assert property (start_q && idx_q == 3'd1
      |-> req_q.addr == 16'h2aaa && req_q.data[7:0] == 8'h55)
      else $error("second unlock write wrong");
   // poll reads keep the last step index, so only sequence writes count
   a_main_code: assert property (start_q && idx_q == 3'd5
      && op_q == flash_host_pkg::OP_MAIN_ERASE
      && st_q == S_SEQ_W
      |-> req_q.wr && req_q.addr == 16'h5555 && req_q.data[7:0] == 8'h30)
      else $error("main erase sixth write wrong");
   a_prog_fourth: assert property (start_q && idx_q == 3'd3
      && op_q == flash_host_pkg::OP_PROGRAM
      && st_q == S_SEQ_W
      |-> req_q.wr && req_q.addr == uaddr_q && req_q.data == wdata_q
      ##1 !start_q [*2])
      else $error("program fourth write wrong");
   a_lock_code: assert property (start_q && idx_q == 3'd5
      && op_q == flash_host_pkg::OP_LOCKOUT
      && st_q == S_SEQ_W
      |-> req_q.addr == 16'h5555 && req_q.data[7:0] == 8'h40)
      else $error("lockout sixth write wrong");
   a_exit_code: assert property (start_q && idx_q == 3'd2
      && op_q == flash_host_pkg::OP_ID_EXIT
      |-> req_q.addr == 16'h5555 && req_q.data[7:0] == 8'hf0)
      else $error("identify exit code wrong");
   a_short_exit: assert property (start_q
      && op_q == flash_host_pkg::OP_ID_EXIT_SHORT
      |-> req_q.wr && req_q.data[7:0] == 8'hf0 && req_q.addr == uaddr_q)
      else $error("single exit write wrong");
   a_poll_after: assert property ($rose(st_q == S_POLL)
      |-> ##1 start_q && !req_q.wr ##1 st_q == S_POLL_W)
      else $error("poll read not issued");

   c_program: cover property (finish && op_q == flash_host_pkg::OP_PROGRAM);
   c_main_erase: cover property (finish
      && op_q == flash_host_pkg::OP_MAIN_ERASE);
   c_lock_seen: cover property ($rose(lock_q));
endmodule

/* src/sync2.sv */
`timescale 1ns/1ns
module sync2 #(
   parameter int WIDTH = 16
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

/* tb/flash_host_tb.sv */
`timescale 1ns/1ns
module flash_host_tb;
   localparam logic [15:0] MFR = 16'h0a5c; // arbitrary value
   localparam logic [15:0] DEV = 16'h0c3a; // arbitrary value
   logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic ce_n, oe_n, we_n, dq_oe, idm, lk;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] flash_addr, dq_o, dq_m, ma, ba, r1, r2;
   logic [32:0] exp_q[$], msk_q[$], e, m;
   int failures, compares, viol, seed, tnum;
   wire logic [15:0] dq_i = dq_oe ? dq_o : dq_m;

   flash_host u_flash_host (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .flash_addr(flash_addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i));
   flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash_model (
      .addr(flash_addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .dq_in(dq_o), .dq_out(dq_m), .viol(viol));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic report_and_stop();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // checker side: the oldest note is matched against each read answer
   always @(posedge ref_clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         if (m !== 33'h0) begin
            compares++;
            if ((({pslverr, prdata} ^ e) & m) !== 33'h0) begin
               failures++;
               $display("wrong value reg %h expected %h seen %h", paddr,
                        e & m, {pslverr, prdata} & m);
            end
         end
      end
   end

   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (int i = 0; i < 50 && pready !== 1'b1; i++) begin
         @(posedge ref_clk);
      end
      if (pready !== 1'b1) begin
         failures++;
         report_and_stop();
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input logic [7:0] a, input logic [32:0] x,
                      input logic [32:0] k);
      exp_q.push_back(x);
      msk_q.push_back(k);
      apb(a, 1'b0, 32'h0);
   endtask

   task automatic dat(input logic [15:0] x);
      chk(flash_host_pkg::REG_RDATA, {17'h0, x}, {33{1'b1}});
   endtask

   // status is checked after done is seen and cleared again
   task automatic op(input flash_host_pkg::op_e o, input logic [15:0] a,
                     input logic [15:0] d, input logic ve);
      apb(flash_host_pkg::REG_ADDR, 1'b1, {16'h0, a});
      apb(flash_host_pkg::REG_WDATA, 1'b1, {16'h0, d});
      apb(flash_host_pkg::REG_CTRL, 1'b1, {29'h0, o});
      rd = 32'h0;
      for (int i = 0; i < 500 && rd[1] !== 1'b1; i++) begin
         chk(flash_host_pkg::REG_STATUS, 33'h0, 33'h0);
      end
      if (rd[1] !== 1'b1) begin
         failures++;
         report_and_stop();
      end
      apb(flash_host_pkg::REG_STATUS, 1'b1, 32'h2);
      chk(flash_host_pkg::REG_STATUS, {28'h0, idm, lk, ve, 2'b0},
          (o == flash_host_pkg::OP_PROGRAM) ? 33'h1f : 33'h1b);
   endtask

   task automatic rdw(input logic [15:0] a, input logic [15:0] x);
      op(flash_host_pkg::OP_READ, a, 16'h0, 1'b0);
      dat(x);
   endtask

   task automatic tst();
      tnum++;
      $display("test %0d finished", tnum);
   endtask

   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, idm, lk} = '0;
      failures = 0;
      compares = 0;
      tnum = 0;
      seed = 32'h1caba434;
      r1 = 16'($random(seed));
      r2 = 16'($random(seed));
      ma = {2'b01, r2[13:0]};
      ba = 16'h1fff;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      chk(flash_host_pkg::REG_STATUS, 33'h0, {33{1'b1}});
      dat(16'h0);
      chk(8'h14, {1'b1, 32'h0}, {33{1'b1}});
      tst();
      op(flash_host_pkg::OP_PROGRAM, ma, r1, 1'b0);
      dat(r1);
      chk(flash_host_pkg::REG_ADDR, {17'h0, ma}, {33{1'b1}});
      chk(flash_host_pkg::REG_WDATA, {17'h0, r1}, {33{1'b1}});
      chk(flash_host_pkg::REG_CTRL, {30'h0, flash_host_pkg::OP_PROGRAM},
          {33{1'b1}});
      op(flash_host_pkg::OP_PROGRAM, ma, r2, (r1 & r2) != r2);
      dat(r1 & r2);
      rdw(ma, r1 & r2);
      op(flash_host_pkg::OP_PROGRAM, ba, r1, 1'b0);
      op(flash_host_pkg::OP_CHIP_ERASE, ma, 16'h0, 1'b0);
      rdw(ba, 16'hffff);
      rdw(ma, 16'hffff);
      tst();
      op(flash_host_pkg::OP_PROGRAM, ba, r1, 1'b0);
      idm = 1'b1;
      op(flash_host_pkg::OP_ID_ENTRY, ma, 16'h0, 1'b0);
      rdw(16'h0, MFR);
      rdw(16'h1, DEV);
      rdw(16'h2, 16'h0);
      idm = 1'b0;
      op(flash_host_pkg::OP_ID_EXIT, ma, 16'h0, 1'b0);
      rdw(16'h0, 16'hffff);
      tst();
      op(flash_host_pkg::OP_LOCKOUT, ma, 16'h0, 1'b0);
      idm = 1'b1;
      op(flash_host_pkg::OP_ID_ENTRY, ma, 16'h0, 1'b0);
      lk = 1'b1;
      rdw(16'h2, 16'h1);
      idm = 1'b0;
      op(flash_host_pkg::OP_ID_EXIT_SHORT, ma, 16'h0, 1'b0);
      op(flash_host_pkg::OP_PROGRAM, ba, 16'h0, r1 != 16'h0);
      dat(r1);
      tst();
      op(flash_host_pkg::OP_PROGRAM, 16'h2000, r2, 1'b0);
      op(flash_host_pkg::OP_MAIN_ERASE, ma, 16'h0, 1'b0);
      rdw(16'h2000, 16'hffff);
      rdw(ba, r1);
      op(flash_host_pkg::OP_PROGRAM, ma, r2, 1'b0);
      op(flash_host_pkg::OP_CHIP_ERASE, ma, 16'h0, 1'b0);
      rdw(ma, 16'hffff);
      rdw(ba, r1);
      tst();
      compares++;
      if (viol != 0) begin
         failures++;
         $display("wrong value write strobes expected 0 seen %0d", viol);
      end
      report_and_stop();
   end
endmodule

/* tb/flash_model.sv */
`timescale 1ns/1ns
module flash_model #(
   parameter logic [15:0] MFR_CODE = 16'h0a5c, // arbitrary value
   parameter logic [15:0] DEV_CODE = 16'h0c3a, // arbitrary value
   parameter int PROG_NS = 400,
   parameter int ERASE_NS = 3000
) (
   input wire logic [15:0] addr,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [15:0] dq_in,
   output logic [15:0] dq_out,
   output int viol
);
   logic [15:0] mem [0:65535];
   logic [15:0] a_q, last_a, last_d, rd_q;
   logic [2:0] step;
   logic id_mode, lock, tog, prog_mode;
   realtime fall_t, busy_end;
   wire wr_n = ce_n | we_n;
   wire rd_n = ce_n | oe_n | !we_n;

   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 16'hffff;
      end
      {a_q, last_a, last_d, rd_q, step, id_mode, lock, tog, prog_mode} = '0;
      viol = 0;
      fall_t = 0;
      busy_end = 0;
   end

   task automatic erase(input logic all);
      for (int i = 0; i < 65536; i++) begin
         if (i > 16'h1fff || (all && !lock)) begin
            mem[i] = 16'hffff;
         end
      end
      busy_end = $realtime + ERASE_NS;
   endtask

   task automatic cmd(input logic [15:0] a, input logic [15:0] w);
      logic [14:0] c;
      logic [7:0] d;
      c = a[14:0];
      d = w[7:0];
      if (prog_mode) begin
         prog_mode = 1'b0;
         last_a = a;
         last_d = w;
         if (!(lock && a <= 16'h1fff)) begin
            mem[a] = mem[a] & w;
         end
         busy_end = $realtime + PROG_NS;
      end else if (step == 3'd0 && d == 8'hf0) begin
         id_mode = 1'b0;
      end else if ((step == 3'd0 || step == 3'd3) && c == 15'h5555
                   && d == 8'haa) begin
         step = step + 3'd1;
      end else if ((step == 3'd1 || step == 3'd4) && c == 15'h2aaa
                   && d == 8'h55) begin
         step = step + 3'd1;
      end else if (step == 3'd2 && c == 15'h5555) begin
         step = (d == 8'h80) ? 3'd3 : 3'd0;
         prog_mode = (d == 8'ha0);
         id_mode = (d == 8'h90) ? 1'b1 : (d == 8'hf0) ? 1'b0 : id_mode;
      end else if (step == 3'd5 && c == 15'h5555) begin
         step = 3'd0;
         if (d == 8'h10 || d == 8'h30) begin
            erase(d == 8'h10);
         end
         lock = lock | (d == 8'h40);
      end else begin
         step = 3'd0;
      end
   endtask

   always @(negedge wr_n) begin
      fall_t = $realtime;
      a_q = addr;
   end

   // glitches and writes during a self-timed operation start nothing
   always @(posedge wr_n) begin
      if (!oe_n) begin
         viol++;
      end else if ($realtime - fall_t >= 15.0 && $realtime >= busy_end) begin
         cmd(a_q, dq_in);
      end
   end

   always @(negedge rd_n) begin
      #1;
      rd_q = mem[addr];
      if ($realtime < busy_end) begin
         tog = !tog;
         rd_q[6] = tog;
         rd_q[7] = (addr == last_a) ? !last_d[7] : rd_q[7];
      end else if (id_mode && addr < 16'h3) begin
         rd_q = (addr == 16'h0) ? MFR_CODE :
                (addr == 16'h1) ? DEV_CODE : {15'h0, lock};
      end
   end

   // no pull on the pins: a released bus shows a changed pattern
   assign dq_out = rd_n ? ~rd_q : rd_q;
endmodule
